// ### logic/dmc_regs.svh
`ifndef DMC_REGS_SVH
`define DMC_REGS_SVH
`define DMC_ADDR_W 32
`define DMC_TAG_HI 23
`define DMC_INDEX_LO 2
`define DMC_INDEX_W_DEF 14
`define DMC_LINE_BYTES 4
`define DMC_PAGE_HIT_WAITS 1
`define DMC_FORCED_MISS_RST 1'b1
`endif

// ### logic/dmc_pkg.sv
package dmc_pkg;
  typedef enum logic [1:0] {
    DMC_REQ_CPU,
    DMC_REQ_DMA,
    DMC_REQ_CHAN
  } dmc_req_type;
  typedef enum {
    DMC_IDLE,
    DMC_DRAM_WAIT
  } dmc_state_type;
endpackage

// ### logic/dmc_lane_merge.sv
`timescale 1ns/1ps
`include "dmc_regs.svh"
module dmc_lane_merge (
  input wire logic [31:0] old_i,
  input wire logic [31:0] new_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] out_o
);
  genvar g;
  generate
    for (g = 0; g < `DMC_LINE_BYTES; g = g + 1) begin : g_lane
      assign out_o[8*g+7:8*g] = sel_i[g] ? new_i[8*g+7:8*g] : old_i[8*g+7:8*g];
    end
  endgenerate
endmodule

// ### logic/dmc_cache_ctrl.sv
`timescale 1ns/1ps
`include "dmc_regs.svh"
module dmc_cache_ctrl
  import dmc_pkg::*;
#(
  parameter int INDEX_W = `DMC_INDEX_W_DEF
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic [1:0] req_src_i,
  input wire logic req_write_i,
  input wire logic [31:0] phys_addr_bits_i,
  input wire logic [3:0] byte_lane_selects_i,
  input wire logic [31:0] req_wdata_i,
  input wire logic req_local_dram_i,
  input wire logic normal_mode_i,
  input wire logic tag_hit_i,
  input wire logic [31:0] cache_rdata_i,
  input wire logic dram_done_i,
  input wire logic [31:0] dram_rdata_i,
  output logic req_done_o,
  output logic [31:0] req_rdata_o,
  output logic dram_req_o,
  output logic dram_write_o,
  output logic [31:0] dram_addr_o,
  output logic [3:0] dram_be_o,
  output logic [31:0] dram_wdata_o,
  output logic cache_we_o,
  output logic [INDEX_W-1:0] cache_index_o,
  output logic [31:0] cache_wdata_o,
  output logic tag_we_o,
  output logic [`DMC_TAG_HI-`DMC_INDEX_LO-INDEX_W:0] tag_wdata_o,
  output logic forced_miss_o
);
  localparam int TAG_LO = `DMC_INDEX_LO + INDEX_W;
  localparam int TAG_W = `DMC_TAG_HI - TAG_LO + 1;

  dmc_state_type state_q;
  logic forced_q;
  logic write_q;
  logic fill_q;
  logic upd_q;
  logic [31:0] wdata_q;
  logic [31:0] addr_q;
  logic [31:0] merged;
  logic [TAG_W-1:0] addr_tag;
  logic [INDEX_W-1:0] addr_index;
  logic hit;
  logic cacheable;
  logic is_cpu;
  logic take;
  logic take_hit;
  logic take_dram;
  logic finish;

  ////////////////////////////////////////////////////////////////////
  // Hit decision
  assign cacheable = req_local_dram_i;
  assign hit = cacheable && tag_hit_i && !forced_q;
  assign is_cpu = (req_src_i == DMC_REQ_CPU);

  // A request is only taken while idle; one waiting on DRAM is not retaken
  assign take = (state_q == DMC_IDLE) && req_valid_i;
  assign take_hit = take && hit && !req_write_i;
  assign take_dram = take && !(hit && !req_write_i);
  assign finish = (state_q == DMC_DRAM_WAIT) && dram_done_i;
  assign addr_index = addr_q[TAG_LO-1:`DMC_INDEX_LO];
  assign addr_tag = addr_q[`DMC_TAG_HI:TAG_LO];

  dmc_lane_merge u_merge (
    .old_i(cache_rdata_i),
    .new_i(req_wdata_i),
    .sel_i(byte_lane_selects_i),
    .out_o(merged)
  );

  ////////////////////////////////////////////////////////////////////
  // Mode: normal mode is a level from the memory configuration control
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      forced_q <= `DMC_FORCED_MISS_RST;
    end else begin
      forced_q <= !normal_mode_i;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= DMC_IDLE;
    end else begin
      case (state_q)
        DMC_IDLE: begin
          if (take_dram) begin
            state_q <= DMC_DRAM_WAIT;
          end
        end
        DMC_DRAM_WAIT: begin
          // Open-page DRAM answers next cycle, giving one wait state
          if (dram_done_i) begin
            state_q <= DMC_IDLE;
          end
        end
        default: begin
          state_q <= DMC_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Captured request, held while DRAM works
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      addr_q <= 32'h0000_0000;
      write_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      upd_q <= 1'b0;
      fill_q <= 1'b0;
    end else if (take_dram) begin
      addr_q <= phys_addr_bits_i;
      write_q <= req_write_i;
      // Merged against the line read at issue; the data SRAM is not reread later
      wdata_q <= merged;
      upd_q <= req_write_i && hit;
      fill_q <= !req_write_i && cacheable && (is_cpu || forced_q);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // DRAM request
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      dram_req_o <= 1'b0;
      dram_write_o <= 1'b0;
      dram_addr_o <= 32'h0000_0000;
      dram_be_o <= 4'h0;
      dram_wdata_o <= 32'h0000_0000;
    end else if (take_dram) begin
      // Write-through: every write and every miss goes to DRAM
      dram_req_o <= 1'b1;
      dram_write_o <= req_write_i;
      dram_addr_o <= phys_addr_bits_i;
      // Reads fetch the whole line so a fill never holds stale lanes
      dram_be_o <= req_write_i ? byte_lane_selects_i : 4'hf;
      dram_wdata_o <= req_wdata_i;
    end else if (finish) begin
      dram_req_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Answer to the requester
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      req_done_o <= 1'b0;
      req_rdata_o <= 32'h0000_0000;
    end else begin
      req_done_o <= take_hit || finish;
      if (take_hit) begin
        req_rdata_o <= cache_rdata_i;
      end else if (finish) begin
        // Writes hand back zero so old read data is never taken for new
        req_rdata_o <= write_q ? 32'h0000_0000 : dram_rdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Data cache write: a write hit merges lanes, a fill writes the line
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cache_we_o <= 1'b0;
      cache_index_o <= '0;
      cache_wdata_o <= 32'h0000_0000;
    end else begin
      cache_we_o <= finish && (upd_q || fill_q);
      if (finish) begin
        cache_index_o <= addr_index;
        if (upd_q) begin
          cache_wdata_o <= wdata_q;
        end else if (fill_q) begin
          cache_wdata_o <= dram_rdata_i;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Tag store write, only on a fill
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tag_we_o <= 1'b0;
      tag_wdata_o <= '0;
    end else begin
      tag_we_o <= finish && fill_q;
      if (finish && fill_q) begin
        tag_wdata_o <= addr_tag;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Mode shown outside with the same timing as the hit path, so both agree
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      forced_miss_o <= `DMC_FORCED_MISS_RST;
    end else begin
      forced_miss_o <= !normal_mode_i;
    end
  end
endmodule

// ### bench/dmc_cache_ctrl_asserts.sv
`timescale 1ns/1ps
module dmc_chk (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic tag_hit_i,
  input wire logic req_local_dram_i,
  input wire logic normal_mode_i,
  input wire logic dram_done_i,
  input wire logic [31:0] dram_rdata_i,
  input wire logic req_done_o,
  input wire logic [31:0] req_rdata_o,
  input wire logic dram_req_o,
  input wire logic dram_write_o,
  input wire logic cache_we_o,
  input wire logic tag_we_o,
  input wire logic forced_miss_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // A request in the done cycle may be retaken; left out to stay safe
  wire go = req_valid_i && !dram_req_o && !req_done_o;
  wire hit = tag_hit_i && req_local_dram_i && !forced_miss_o && !req_write_i;
  wire fin = dram_done_i && dram_req_o;
  a_hit_zero_wait: assert property (go && hit |=> req_done_o && !dram_req_o)
    else $error("read hit late");
  a_miss_to_dram: assert property (go && !hit |=> dram_req_o && !req_done_o)
    else $error("miss not sent");
  a_done_after: assert property (fin |=> req_done_o && !dram_req_o)
    else $error("done late");
  a_read_data: assert property (fin && !dram_write_o |=> req_rdata_o == $past(dram_rdata_i))
    else $error("bad read data");
  a_write_no_tag: assert property (fin && dram_write_o |=> !tag_we_o)
    else $error("write filled tag");
  a_forced_fill: assert property (fin && !dram_write_o && forced_miss_o && req_local_dram_i
    |=> tag_we_o && cache_we_o) else $error("no fill");
  a_nc_no_fill: assert property (fin && !req_local_dram_i |=> !cache_we_o && !tag_we_o)
    else $error("uncached fill");
  a_mode_follow: assert property (normal_mode_i [*2] |=> !forced_miss_o)
    else $error("mode stuck");
  a_mode_forced: assert property (!normal_mode_i |=> forced_miss_o)
    else $error("forced mode lost");
endmodule
bind dmc_cache_ctrl dmc_chk u_chk (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .req_valid_i(req_valid_i),
  .req_write_i(req_write_i),
  .tag_hit_i(tag_hit_i),
  .req_local_dram_i(req_local_dram_i),
  .normal_mode_i(normal_mode_i),
  .dram_done_i(dram_done_i),
  .dram_rdata_i(dram_rdata_i),
  .req_done_o(req_done_o),
  .req_rdata_o(req_rdata_o),
  .dram_req_o(dram_req_o),
  .dram_write_o(dram_write_o),
  .cache_we_o(cache_we_o),
  .tag_we_o(tag_we_o),
  .forced_miss_o(forced_miss_o)
);

// ### bench/dmc_dram_model.sv
`timescale 1ns/1ps
module dmc_dram_model (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic [31:0] addr_i,
  output logic done_o = 0,
  output logic [31:0] rdata_o = 0
);
  int n = 0;
  // Idle data keeps changing so stale data cannot pass
  always @(posedge clk_i) begin
    n <= req_i ? n + 1 : 0;
    done_o <= req_i && n == 0;
    rdata_o <= (req_i && n == 0) ? ~addr_i : ~rdata_o;
  end
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic sys_clk_i = 0, rst_i = 1, req_valid_i = 0, req_write_i = 0, req_local_dram_i = 1;
  logic normal_mode_i = 0, tag_hit_i = 1, dram_done_i, req_done_o, dram_req_o, dram_write_o;
  logic cache_we_o, tag_we_o, forced_miss_o;
  logic [1:0] req_src_i = 0;
  logic [3:0] byte_lane_selects_i = 4'hf, dram_be_o;
  logic [31:0] phys_addr_bits_i = 0, req_wdata_i = 0, cache_rdata_i = 0, dram_rdata_i;
  logic [31:0] req_rdata_o, dram_addr_o, dram_wdata_o, cache_wdata_o, fill_data;
  logic [13:0] cache_index_o;
  logic [7:0] tag_wdata_o;
  int n_errors = 0, comparisons = 0, cyc = 0, fills = 0, tags = 0, n;
  dmc_cache_ctrl dut (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .req_valid_i(req_valid_i),
    .req_src_i(req_src_i),
    .req_write_i(req_write_i),
    .phys_addr_bits_i(phys_addr_bits_i),
    .byte_lane_selects_i(byte_lane_selects_i),
    .req_wdata_i(req_wdata_i),
    .req_local_dram_i(req_local_dram_i),
    .normal_mode_i(normal_mode_i),
    .tag_hit_i(tag_hit_i),
    .cache_rdata_i(cache_rdata_i),
    .dram_done_i(dram_done_i),
    .dram_rdata_i(dram_rdata_i),
    .req_done_o(req_done_o),
    .req_rdata_o(req_rdata_o),
    .dram_req_o(dram_req_o),
    .dram_write_o(dram_write_o),
    .dram_addr_o(dram_addr_o),
    .dram_be_o(dram_be_o),
    .dram_wdata_o(dram_wdata_o),
    .cache_we_o(cache_we_o),
    .cache_index_o(cache_index_o),
    .cache_wdata_o(cache_wdata_o),
    .tag_we_o(tag_we_o),
    .tag_wdata_o(tag_wdata_o),
    .forced_miss_o(forced_miss_o)
  );
  dmc_dram_model mem (.clk_i(sys_clk_i), .req_i(dram_req_o), .addr_i(dram_addr_o),
    .done_o(dram_done_i), .rdata_o(dram_rdata_i));
  initial forever #4 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cache_we_o === 1'b1) begin
      fills <= fills + 1;
      fill_data <= cache_wdata_o;
    end
    if (tag_we_o === 1'b1) begin
      tags <= tags + 1;
    end
    if (cyc == 2000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic req(input logic [1:0] s, input logic w, input logic [31:0] a);
    @(negedge sys_clk_i);
    {req_src_i, req_write_i, phys_addr_bits_i, req_valid_i, n} = {s, w, a, 1'b1, 32'h0};
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (req_done_o !== 1'b1 && n < 50);
    req_valid_i = 0;
    @(negedge sys_clk_i);
  endtask
  task automatic t_forced();
    chk(forced_miss_o, 32'h0000_0001);
    req(0, 0, 32'h0001_0010);
    chk(cache_index_o, 32'h0000_0004);
    chk(tag_wdata_o, 32'h0000_0001);
    chk(n, 3);
    chk(req_rdata_o, ~32'h0001_0010);
    chk(fill_data, ~32'h0001_0010);
    req(0, 1, 32'h0001_0010);
    chk(fills, 1);
  endtask
  task automatic t_hit();
    normal_mode_i = 1;
    repeat (2) @(negedge sys_clk_i);
    chk(forced_miss_o, 32'h0000_0000);
    cache_rdata_i = 32'haabb_ccdd;
    req(0, 0, 32'h0000_0020);
    chk(n, 1);
    chk(req_rdata_o, 32'haabb_ccdd);
    byte_lane_selects_i = 4'h5;
    req_wdata_i = 32'h1122_3344;
    req(2, 1, 32'h0000_0020);
    chk(fill_data, 32'haa22_cc44);
    chk(cache_index_o, 32'h0000_0008);
    chk(dram_write_o, 32'h0000_0001);
    chk(dram_addr_o, 32'h0000_0020);
    chk(dram_be_o, 32'h0000_0005);
    chk(dram_wdata_o, 32'h1122_3344);
  endtask
  task automatic t_side();
    tag_hit_i = 0;
    req(1, 0, 32'h0000_0044);
    chk(req_rdata_o, ~32'h0000_0044);
    req(2, 1, 32'h0000_0044);
    chk(fills, 2);
    tag_hit_i = 1;
    req_local_dram_i = 0;
    req(0, 0, 32'h0000_0048);
    chk(n, 3);
    chk(fills, 2);
    chk(tags, 1);
  endtask
  task automatic give_verdict();
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge sys_clk_i);
    rst_i = 0;
    t_forced();
    t_hit();
    t_side();
    give_verdict();
  end
endmodule
